/* File: rtl/tap_instruction_scan_paths.sv */
`timescale 1ns/1ns
module tap_instruction_scan_paths
  import tap_pkg::*;
(
  // System clock and reset.
  input  wire logic             CLK,
  input  wire logic             RSTN,
  // Test pins.
  input  wire logic             TCK,
  input  wire logic             TMS,
  input  wire logic             TDI,
  output logic                  TDO,
  output logic                  TDO_OE_N,
  // SRAM ball levels and output control.
  input  wire logic [BSR_W-1:0] RING,
  output logic                  OUTPUT_HIZ
);

  jtag_in_t         pin_s1_r;
  jtag_in_t         pin_s2_r;
  logic             tck_d_r;
  logic [BSR_W-1:0] ring_s1_r;
  logic [BSR_W-1:0] ring_s2_r;
  tap_state_t       state_r;
  tap_state_t       state_nxt;
  logic [IR_W-1:0]  ir_sh_r;
  logic [IR_W-1:0]  instr_r;
  logic [ID_W-1:0]  id_sh_r;
  logic [BSR_W-1:0] bsr_r;
  logic             byp_r;
  logic             tdo_r;
  logic             oe_n_r;
  logic             hiz_r;
  logic [2:0]       tms_cnt_r;

  // Pins pass two flip-flops; edges are found on the second stage.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      tck_d_r   <= 1'b0;
      ring_s1_r <= '0;
      ring_s2_r <= '0;
    end else begin
      pin_s1_r  <= '{tck: TCK, tms: TMS, tdi: TDI};
      pin_s2_r  <= pin_s1_r;
      tck_d_r   <= pin_s2_r.tck;
      ring_s1_r <= RING;
      ring_s2_r <= ring_s1_r;
    end
  end

  // Edge strobes, instruction decode and selected data register bit.
  wire tck_rise = pin_s2_r.tck & ~tck_d_r;
  wire tck_fall = ~pin_s2_r.tck & tck_d_r;
  wire tms      = pin_s2_r.tms;
  wire tdi      = pin_s2_r.tdi;
  // Every capture code uses the boundary register; unknown codes fall to bypass.
  wire sel_bsr  = (instr_r == INS_EXTEST) | (instr_r == INS_SAMPLEZ) |
                  (instr_r == INS_SAMPLE);
  wire sel_id   = (instr_r == INS_IDCODE);
  wire dr_lsb   = sel_bsr ? bsr_r[0] : (sel_id ? id_sh_r[0] : byp_r);
  wire shifting = (state_r == ST_SH_DR) | (state_r == ST_SH_IR);
  wire hiz_nxt  = (instr_r == INS_SAMPLEZ) | (instr_r == INS_EXTEST);

  // Standard TAP transitions on the sampled TMS level.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_TLR:    state_nxt = tms ? ST_TLR    : ST_RTI;
      ST_RTI:    state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  state_nxt = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_nxt = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  state_nxt = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
    endcase
  end

  // State steps once per rising test clock edge.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // Instruction shifter and active instruction.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ir_sh_r <= IR_CAPTURE;
      instr_r <= INS_IDCODE;
    end else if (state_r == ST_TLR) begin
      instr_r <= INS_IDCODE;
    end else if (tck_rise) begin
      if (state_r == ST_CAP_IR) begin
        ir_sh_r <= IR_CAPTURE;
      end else if (state_r == ST_SH_IR) begin
        ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
      end else if (state_r == ST_UPD_IR) begin
        instr_r <= ir_sh_r;
      end
    end
  end

  // Data registers capture in Capture-DR and shift toward TDO in Shift-DR.
  // Update-DR has no branch: there is no preload stage to load.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      id_sh_r <= '0;
      bsr_r   <= '0;
      byp_r   <= 1'b0;
    end else if (tck_rise && state_r == ST_CAP_DR) begin
      if (sel_id) id_sh_r <= IDCODE_VALUE;
      if (sel_bsr) bsr_r <= ring_s2_r;
      byp_r <= 1'b0;
    end else if (tck_rise && state_r == ST_SH_DR) begin
      if (sel_id) id_sh_r <= {tdi, id_sh_r[ID_W-1:1]};
      if (sel_bsr) bsr_r <= {tdi, bsr_r[BSR_W-1:1]};
      byp_r <= tdi;
    end
  end

  // TDO changes on the falling test clock edge and floats outside shifting.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tdo_r  <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (tck_fall) begin
      tdo_r  <= (state_r == ST_SH_IR) ? ir_sh_r[0] : dr_lsb;
      oe_n_r <= ~shifting;
    end
  end

  // SRAM drivers are held off while an outputs-off instruction is active.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hiz_r <= 1'b0;
    end else begin
      hiz_r <= hiz_nxt;
    end
  end

  assign TDO        = tdo_r;
  assign TDO_OE_N   = oe_n_r;
  assign OUTPUT_HIZ = hiz_r;

  // Helper: consecutive TMS-high rising edges, saturating.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tms_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      if (!tms) tms_cnt_r <= 3'h0;
      else if (tms_cnt_r != TMS_RESET_EDGES) tms_cnt_r <= tms_cnt_r + 3'h1;
    end
  end

  // All checks run on the system clock and are quiet while reset is held.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_ID_RESET: assert property (state_r == ST_TLR |=> instr_r == INS_IDCODE)
    else $error("Reset state did not select the ID instruction.");
  AST_HIZ_ON: assert property (instr_r == INS_SAMPLEZ |=> OUTPUT_HIZ)
    else $error("Outputs-off sample did not float the SRAM outputs.");
  AST_SAMPLE_NO_HIZ: assert property (instr_r == INS_SAMPLE |=> !OUTPUT_HIZ)
    else $error("Sample instruction disturbed the SRAM outputs.");
  AST_ID_CAPTURE: assert property (tck_rise && state_r == ST_CAP_DR && sel_id
    |=> id_sh_r == IDCODE_VALUE)
    else $error("ID code not loaded in Capture-DR.");
  AST_BSR_CAPTURE: assert property (tck_rise && state_r == ST_CAP_DR && sel_bsr
    |=> bsr_r == $past(ring_s2_r))
    else $error("Boundary register did not capture the ball levels.");
  AST_BYPASS_SHIFT: assert property (tck_rise && state_r == ST_SH_DR
    && instr_r == INS_BYPASS |=> byp_r == $past(tdi))
    else $error("Bypass bit did not take TDI.");
  AST_TMS_RESET: assert property (tms_cnt_r == TMS_RESET_EDGES |-> state_r == ST_TLR)
    else $error("Five TMS-high edges did not reset the TAP.");
  AST_TDO_BSR: assert property (tck_fall && state_r == ST_SH_DR && sel_bsr
    |=> TDO == $past(bsr_r[0]) && !TDO_OE_N)
    else $error("TDO does not show the boundary register in Shift-DR.");
  AST_UPD_DR_QUIET: assert property (state_r == ST_UPD_DR
    |=> $stable(bsr_r) && $stable(OUTPUT_HIZ))
    else $error("Update-DR changed the boundary register or the SRAM outputs.");
  AST_TDO_FLOAT: assert property (tck_fall && !shifting |=> TDO_OE_N)
    else $error("TDO driven outside a shift state.");

  // Instruction path: fixed capture pattern, update copies the shifter, TDO shows its LSB.
  AST_IR_CAPTURE: assert property (tck_rise && state_r == ST_CAP_IR
    |=> ir_sh_r == IR_CAPTURE)
    else $error("Instruction shifter did not load the capture pattern.");
  AST_IR_UPDATE: assert property (tck_rise && state_r == ST_UPD_IR
    |=> instr_r == $past(ir_sh_r))
    else $error("Update-IR did not make the shifted code active.");
  AST_TDO_IR: assert property (tck_fall && state_r == ST_SH_IR
    |=> TDO == $past(ir_sh_r[0]) && !TDO_OE_N)
    else $error("TDO does not show the instruction shifter in Shift-IR.");

  // Data paths: the active instruction puts the ID, bypass or shared boundary register in front of TDO.
  AST_TDO_ID: assert property (tck_fall && state_r == ST_SH_DR && sel_id
    |=> TDO == $past(id_sh_r[0]) && !TDO_OE_N)
    else $error("TDO does not show the ID register in Shift-DR.");
  AST_TDO_BYPASS: assert property (tck_fall && state_r == ST_SH_DR
    && instr_r == INS_BYPASS |=> TDO == $past(byp_r) && !TDO_OE_N)
    else $error("TDO does not show the bypass bit in Shift-DR.");
  AST_BSR_SHIFT: assert property (tck_rise && state_r == ST_SH_DR && sel_bsr
    |=> bsr_r == {$past(tdi), $past(bsr_r[BSR_W-1:1])})
    else $error("Boundary register did not shift one place toward TDO.");

  // SRAM drivers stay on for instructions that must not disturb the SRAM.
  AST_HIZ_OFF: assert property (instr_r == INS_IDCODE || instr_r == INS_BYPASS
    |=> !OUTPUT_HIZ)
    else $error("ID or bypass instruction floated the SRAM outputs.");

endmodule

/* File: rtl/tap_pkg.sv */
package tap_pkg;

  // Scan path lengths.
  localparam int IR_W  = 3;
  localparam int ID_W  = 32;
  localparam int BSR_W = 75;

  // Instruction codes, least significant bit shifted first.
  localparam logic [2:0] INS_EXTEST  = 3'h0;
  localparam logic [2:0] INS_IDCODE  = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE  = 3'h4;
  localparam logic [2:0] INS_BYPASS  = 3'h7;

  // Pattern loaded into the instruction shifter in Capture-IR.
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // Identification value; arbitrary, bit 0 marks the ID register present.
  localparam logic [31:0] IDCODE_VALUE = 32'h0123_4567;

  // Consecutive TMS-high rising edges that always reach reset.
  localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

  // TAP controller states.
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;

  // Test pins travelling together through the synchroniser.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_in_t;

endpackage

/* File: dv/jtag_ctrl_model.sv */
`timescale 1ns/1ns
module jtag_ctrl_model (
  // System clock used to pace the test clock.
  input  wire logic CLK,
  // Test pins.
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // Test clock stands low between frames; pulled-up lines idle high.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One 48 ns test clock; TDO is read just before the rise.
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge CLK);
    tms = m;
    tdi = d;
    repeat (5) @(negedge CLK);
    q   = tdo;
    tck = 1'b1;
    repeat (6) @(negedge CLK);
    tck = 1'b0;
  endtask

  // Five TMS-high edges reach reset, then park in Run-Test/Idle.
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask

  // Scan n bits LSB first through IR or DR, ending in Run-Test/Idle.
  task automatic scan(input logic ir, input int n, input logic [74:0] din,
                      output logic [74:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule

/* File: dv/tap_instruction_scan_paths_tb.sv */
`timescale 1ns/1ns
module tap_instruction_scan_paths_tb;
  import tap_pkg::*;
  logic             clk, rstn, tck, tms, tdi, tdo, tdo_oe_n, output_hiz, tdo_w;
  logic [BSR_W-1:0] ring;
  logic [74:0]      got;
  int               error_cnt;
  int               compares;

  // A released TDO line shows the inverse of its last value.
  assign tdo_w = tdo_oe_n ? ~tdo : tdo;

  tap_instruction_scan_paths tap_instruction_scan_paths_i (
    .CLK(clk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE_N(tdo_oe_n), .RING(ring), .OUTPUT_HIZ(output_hiz));

  jtag_ctrl_model jtag_ctrl_model_i (
    .CLK(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

  // Compare and count.
  task automatic check(input logic [74:0] seen, input logic [74:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run.
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Identification code read through the data path.
  task automatic t_idcode();
    jtag_ctrl_model_i.scan(1'b0, ID_W, '1, got);
    check(got, 75'(IDCODE_VALUE));
  endtask

  // Load an instruction, then shift its data path with ones behind it.
  task automatic t_path(input logic [2:0] code, input logic hiz, input int n,
                        input logic [74:0] exp);
    jtag_ctrl_model_i.scan(1'b1, IR_W, 75'(code), got);
    check(got, 75'(IR_CAPTURE));
    check(75'(output_hiz), 75'(hiz));
    jtag_ctrl_model_i.scan(1'b0, n, '1, got);
    check(got, exp);
    check(75'(tdo_oe_n), 75'h1);
    check(75'(output_hiz), 75'(hiz));
  endtask

  // Five-edge reset from a high-Z instruction returns to the ID code.
  task automatic t_tapreset();
    jtag_ctrl_model_i.reset_tap();
    check(75'(output_hiz), 75'h0);
    t_idcode();
  endtask

  // System clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  // Main sequence; ring levels are held steady across each capture.
  initial begin
    rstn = 1'b0;
    ring = 75'h5a5_1234_5678_9abc_def0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    jtag_ctrl_model_i.reset_tap();
    t_idcode();
    // Only implemented codes are issued.
    t_path(INS_SAMPLEZ, 1'b1, BSR_W, ring);
    ring = 75'h3c3_0f0f_f0f0_5555_aaaa;
    t_path(INS_SAMPLE, 1'b0, BSR_W, ring);
    ring = 75'h1e1_8001_7ffe_0000_ffff;
    t_path(INS_EXTEST, 1'b1, BSR_W, ring);
    t_path(INS_BYPASS, 1'b0, 2, 75'h2);
    t_path(INS_SAMPLEZ, 1'b1, BSR_W, ring);
    t_tapreset();
    end_sim();
  end
endmodule
